// File: rtl/simd_x87_state_enable_control.sv
/*
  simd/x87 state and enable control: feature reporting, os enable gating,
  extended control register writes, simd exception routing and the
  architectural state of the vector, media and x87 units.
  assumes execution requests and register strobes come from logic on the
  same clock; strobes are single cycle and never overlap.
*/
// The implementer's own choices: strobed register access and the register addresses.
// Overview of operation
// - ext save flag only with full support
// - report optimized save flag, sub-function one
// - supported mask bits x87, legacy, extended
// - extended support implies x87 and legacy
// - ext ctrl access needs os enable bit
// - ext ctrl write privileged, sole write path
// - extended without legacy state not allowed
// - x87 state bit must stay set
// - save area size follows enabled set
// - unmasked simd exception: handler or invalid opcode
// - masked simd exception takes default response
// - sixteen wide vector regs, eight legacy
// - one 32-bit simd control status register
// - media regs alias low fp bits
// - media ops update top and tags
// - media ops raise no x87 flags
// - media op raises pending x87 exception
// - record last instruction and data pointers
// - build 11-bit last opcode value
// - software writes only data, control, status
// - eight 80-bit fp regs plus words
// - legacy simd needs save support, no emulation
// - task switched with monitor gives not-available
`timescale 1ns/10ps
`default_nettype none
module simd_x87_state_enable_control
  import simd_x87_pkg::*;
#(
  parameter logic [2:0] SUPPORT_MASK = 3'h7,
  parameter bit OPT_SAVE_PRESENT = 1'b1,
  parameter logic [31:0] LEGACY_AREA_BYTES = 32'd576,
  parameter logic [31:0] EXT_AREA_BYTES = 32'd256
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic op_valid_i,
  input wire logic [2:0] op_class_i,
  input wire logic op_priv_i,
  input wire logic op_legacy_mode_i,
  input wire logic op_write_i,
  input wire logic op_empty_tags_i,
  input wire logic [3:0] op_reg_idx_i,
  input wire logic [63:0] op_ctrl_value_i,
  input wire logic [79:0] op_fp_data_i,
  input wire logic [63:0] op_media_data_i,
  input wire logic [255:0] op_vec_data_i,
  input wire logic op_vec_wide_i,
  input wire logic op_noncontrol_i,
  input wire logic [15:0] op_opcode_i,
  input wire logic [63:0] op_ip_i,
  input wire logic [63:0] op_dp_i,
  input wire logic op_has_mem_i,
  input wire logic simd_exc_i,
  input wire logic simd_exc_masked_i,
  output logic fault_o,
  output logic [2:0] fault_code_o,
  output logic [63:0] ext_ctrl_rdata_o,
  output logic [255:0] vec_rdata_o,
  output logic [63:0] media_rdata_o,
  output logic [63:0] last_ip_o,
  output logic [63:0] last_dp_o
);
  op_class_t op_class;
  fault_t fault_d;
  logic [2:0] supported;
  logic [31:0] flags;
  logic [31:0] save_size;
  logic [31:0] os_ctrl_q;
  logic [31:0] coproc_q;
  logic [2:0] enabled_q;
  logic [31:0] simd_cs_q;
  logic [15:0] fp_control_q;
  logic [15:0] fp_status_q;
  logic [15:0] fp_tag_q;
  logic [10:0] last_op_q;
  logic [2:0] fp_sel_q;
  logic [79:0] fpr_q [8];
  logic [255:0] vec_q [16];
  logic go;
  logic bad_value;
  logic dna;

  assign op_class = op_class_t'(op_class_i);

  // extended bit only survives when both lower subsets exist
  always_comb begin
    supported = SUPPORT_MASK;
    if (!(SUPPORT_MASK[FEAT_X87_BIT] && SUPPORT_MASK[FEAT_LEGACY_BIT])) begin
      supported[FEAT_EXT_BIT] = 1'b0;
    end
  end

  // feature flags; save flag needs the whole extended set
  always_comb begin
    flags = 32'h0;
    flags[FLAG_EXT_SAVE_BIT] = (supported == FEAT_ALL);
    flags[FLAG_OPT_SAVE_BIT] = OPT_SAVE_PRESENT && (supported == FEAT_ALL);
  end

  // recomputed every cycle so it can never lag the enabled set
  always_comb begin
    save_size = LEGACY_AREA_BYTES;
    if (enabled_q[FEAT_EXT_BIT]) begin
      save_size = 32'(LEGACY_AREA_BYTES + EXT_AREA_BYTES);
    end
  end

  // value check for an extended control write
  assign bad_value = !op_ctrl_value_i[FEAT_X87_BIT]
    || (op_ctrl_value_i[FEAT_EXT_BIT] && !op_ctrl_value_i[FEAT_LEGACY_BIT])
    || (op_ctrl_value_i[2:0] & ~supported) != 3'h0
    || op_ctrl_value_i[63:3] != 61'h0;

  assign dna = !coproc_q[COPROC_EMULATION_BIT] && coproc_q[COPROC_MONITOR_BIT]
    && coproc_q[TASK_SWITCHED_BIT];

  // fault selection; first matching cause wins
  always_comb begin
    fault_d = FAULT_NONE;
    if (op_valid_i) begin
      unique case (op_class)
        OP_X87, OP_WAIT: begin
          if (dna) begin
            fault_d = FAULT_DEVICE_NOT_AVAILABLE;
          end
        end
        OP_MEDIA64: begin
          if (dna) begin
            fault_d = FAULT_DEVICE_NOT_AVAILABLE;
          end else if (fp_status_q[STATUS_SUMMARY_BIT]) begin
            fault_d = FAULT_X87_PENDING;
          end
        end
        OP_LEGACY_SIMD, OP_EXT_SIMD: begin
          if (!os_ctrl_q[OS_LEGACY_SAVE_BIT] || coproc_q[COPROC_EMULATION_BIT]) begin
            fault_d = FAULT_INVALID_OPCODE;
          end else if (op_class == OP_EXT_SIMD && !enabled_q[FEAT_EXT_BIT]) begin
            fault_d = FAULT_INVALID_OPCODE;
          end else if (dna) begin
            fault_d = FAULT_DEVICE_NOT_AVAILABLE;
          end else if (op_legacy_mode_i && op_reg_idx_i[3]) begin
            fault_d = FAULT_INVALID_OPCODE;
          end else if (simd_exc_i && !simd_exc_masked_i) begin
            fault_d = os_ctrl_q[OS_SIMD_EXC_BIT] ? FAULT_SIMD_FP
              : FAULT_INVALID_OPCODE;
          end
        end
        OP_EXT_CTRL_WRITE: begin
          if (!os_ctrl_q[OS_EXT_SAVE_BIT]) begin
            fault_d = FAULT_INVALID_OPCODE;
          end else if (!op_priv_i) begin
            fault_d = FAULT_GENERAL_PROTECTION;
          end else if (bad_value) begin
            fault_d = FAULT_GENERAL_PROTECTION;
          end
        end
        OP_EXT_CTRL_READ: begin
          if (!os_ctrl_q[OS_EXT_SAVE_BIT]) begin
            fault_d = FAULT_INVALID_OPCODE;
          end
        end
        OP_NONE: fault_d = FAULT_NONE;
      endcase
    end
  end

  // an operation commits only when it raised no fault
  assign go = op_valid_i && (fault_d == FAULT_NONE);

  // fault report, one-cycle pulse
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_o <= 1'b0;
      fault_code_o <= 3'h0;
    end else begin
      fault_o <= (fault_d != FAULT_NONE);
      fault_code_o <= fault_d;
    end
  end

  // os and coprocessor control, software written
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      os_ctrl_q <= 32'h0;
      coproc_q <= 32'h0;
      fp_sel_q <= 3'h0;
    end else if (reg_we_i) begin
      if (reg_addr_i == IDX_OS_FEATURE_CTRL) begin
        os_ctrl_q <= reg_wdata_i;
      end
      if (reg_addr_i == IDX_COPROC_CTRL) begin
        coproc_q <= reg_wdata_i;
      end
      if (reg_addr_i == IDX_FP_REG_SELECT) begin
        fp_sel_q <= reg_wdata_i[2:0];
      end
    end
  end

  // enabled set: only the privileged write instruction reaches it, so a bus
  // write to its index is ignored
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enabled_q <= FEAT_RESET;
      ext_ctrl_rdata_o <= 64'h0;
    end else begin
      if (go && op_class == OP_EXT_CTRL_WRITE) begin
        enabled_q <= op_ctrl_value_i[2:0];
      end
      if (go && op_class == OP_EXT_CTRL_READ) begin
        ext_ctrl_rdata_o <= {61'h0, enabled_q};
      end
    end
  end

  // simd control/status and x87 control word, software visible
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      simd_cs_q <= SIMD_CS_RESET;
      fp_control_q <= FP_CONTROL_RESET;
    end else if (reg_we_i) begin
      if (reg_addr_i == IDX_SIMD_CONTROL_STATUS) begin
        simd_cs_q <= reg_wdata_i;
      end
      if (reg_addr_i == IDX_FP_CONTROL_WORD) begin
        fp_control_q <= reg_wdata_i[15:0];
      end
    end
  end

  // status word: software writes it, media ops only touch top
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fp_status_q <= FP_STATUS_RESET;
    end else if (reg_we_i && reg_addr_i == IDX_FP_STATUS_WORD) begin
      fp_status_q <= reg_wdata_i[15:0];
    end else if (go && op_class == OP_MEDIA64) begin
      fp_status_q[STATUS_TOP_LSB +: 3] <= 3'h0;
    end
  end

  // tag word kept by hardware only; bus writes have no effect
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fp_tag_q <= TAGS_ALL_EMPTY;
    end else if (go && op_class == OP_MEDIA64) begin
      fp_tag_q <= op_empty_tags_i ? TAGS_ALL_EMPTY : TAGS_ALL_VALID;
    end else if (go && op_class == OP_X87 && op_write_i) begin
      fp_tag_q[{op_reg_idx_i[2:0], 1'b0} +: 2] <= TAG_VALID;
    end
  end

  // last instruction pointer, data pointer and opcode
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_op_q <= 11'h0;
      last_ip_o <= 64'h0;
      last_dp_o <= 64'h0;
    end else if (go && op_class == OP_X87 && op_noncontrol_i) begin
      last_op_q <= {op_opcode_i[10:8], op_opcode_i[7:0]};
      last_ip_o <= op_ip_i;
      if (op_has_mem_i) begin
        last_dp_o <= op_dp_i;
      end
    end
  end

  // fp physical registers; the media view writes the low 64 bits and
  // forces the exponent field to ones, as a media write does
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 8; i++) begin
        fpr_q[i] <= 80'h0;
      end
    end else if (reg_we_i && reg_addr_i == IDX_FP_REG_LO) begin
      fpr_q[fp_sel_q][31:0] <= reg_wdata_i;
    end else if (reg_we_i && reg_addr_i == IDX_FP_REG_MID) begin
      fpr_q[fp_sel_q][63:32] <= reg_wdata_i;
    end else if (reg_we_i && reg_addr_i == IDX_FP_REG_HI) begin
      fpr_q[fp_sel_q][79:64] <= reg_wdata_i[15:0];
    end else if (go && op_write_i && op_class == OP_X87) begin
      fpr_q[op_reg_idx_i[2:0]] <= op_fp_data_i;
    end else if (go && op_write_i && op_class == OP_MEDIA64) begin
      fpr_q[op_reg_idx_i[2:0]] <= {16'hffff, op_media_data_i};
    end
  end

  // media read view taken from the shared storage
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      media_rdata_o <= 64'h0;
    end else if (go && op_class == OP_MEDIA64) begin
      media_rdata_o <= fpr_q[op_reg_idx_i[2:0]][63:0];
    end
  end

  // vector registers; a narrow write leaves the upper half alone
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 16; i++) begin
        vec_q[i] <= 256'h0;
      end
      vec_rdata_o <= 256'h0;
    end else if (go && (op_class == OP_LEGACY_SIMD || op_class == OP_EXT_SIMD)) begin
      vec_rdata_o <= vec_q[op_reg_idx_i];
      if (op_write_i && op_vec_wide_i && op_class == OP_EXT_SIMD) begin
        vec_q[op_reg_idx_i] <= op_vec_data_i;
      end else if (op_write_i) begin
        vec_q[op_reg_idx_i][127:0] <= op_vec_data_i[127:0];
      end
    end
  end

  // a masked simd exception needs no action here: the default response
  // is the unit's own, so it never reaches the fault path above

  // register read data, valid the cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        IDX_OS_FEATURE_CTRL: reg_rdata_o <= os_ctrl_q;
        IDX_COPROC_CTRL: reg_rdata_o <= coproc_q;
        IDX_ENABLED_FEATURES: reg_rdata_o <= {29'h0, enabled_q};
        IDX_SUPPORTED_FEATURES: reg_rdata_o <= {29'h0, supported};
        IDX_SAVE_AREA_SIZE: reg_rdata_o <= save_size;
        IDX_FEATURE_FLAGS: reg_rdata_o <= flags;
        IDX_SIMD_CONTROL_STATUS: reg_rdata_o <= simd_cs_q;
        IDX_FP_CONTROL_WORD: reg_rdata_o <= {16'h0, fp_control_q};
        IDX_FP_STATUS_WORD: reg_rdata_o <= {16'h0, fp_status_q};
        IDX_FP_TAG_WORD: reg_rdata_o <= {16'h0, fp_tag_q};
        IDX_LAST_FP_OPCODE: reg_rdata_o <= {21'h0, last_op_q};
        IDX_FP_REG_SELECT: reg_rdata_o <= {29'h0, fp_sel_q};
        IDX_FP_REG_LO: reg_rdata_o <= fpr_q[fp_sel_q][31:0];
        IDX_FP_REG_MID: reg_rdata_o <= fpr_q[fp_sel_q][63:32];
        IDX_FP_REG_HI: reg_rdata_o <= {16'h0, fpr_q[fp_sel_q][79:64]};
        default: reg_rdata_o <= 32'h0; // unmapped index reads zero
      endcase
    end
  end
endmodule : simd_x87_state_enable_control
`default_nettype wire

// File: shared/simd_x87_pkg.sv
/*
  constants, register map and enumerations for the simd/x87 state and
  enable control block.
  assumes a single core clock and a word-indexed register port.
*/
package simd_x87_pkg;
  // register indices on the plain register port (byte address = 4 * index)
  localparam logic [7:0] IDX_OS_FEATURE_CTRL = 8'h00;
  localparam logic [7:0] IDX_COPROC_CTRL = 8'h01;
  localparam logic [7:0] IDX_ENABLED_FEATURES = 8'h02;
  localparam logic [7:0] IDX_SUPPORTED_FEATURES = 8'h03;
  localparam logic [7:0] IDX_SAVE_AREA_SIZE = 8'h04;
  localparam logic [7:0] IDX_FEATURE_FLAGS = 8'h05;
  localparam logic [7:0] IDX_SIMD_CONTROL_STATUS = 8'h06;
  localparam logic [7:0] IDX_FP_CONTROL_WORD = 8'h07;
  localparam logic [7:0] IDX_FP_STATUS_WORD = 8'h08;
  localparam logic [7:0] IDX_FP_TAG_WORD = 8'h09;
  localparam logic [7:0] IDX_LAST_FP_OPCODE = 8'h0a;
  localparam logic [7:0] IDX_FP_REG_SELECT = 8'h0b;
  localparam logic [7:0] IDX_FP_REG_LO = 8'h0c;
  localparam logic [7:0] IDX_FP_REG_MID = 8'h0d;
  localparam logic [7:0] IDX_FP_REG_HI = 8'h0e;
  // os feature control bit positions
  localparam int OS_LEGACY_SAVE_BIT = 9;
  localparam int OS_SIMD_EXC_BIT = 10;
  localparam int OS_EXT_SAVE_BIT = 18;
  // coprocessor control bit positions
  localparam int COPROC_MONITOR_BIT = 1;
  localparam int COPROC_EMULATION_BIT = 2;
  localparam int TASK_SWITCHED_BIT = 3;
  // feature enable / supported set layout
  localparam int FEAT_X87_BIT = 0;
  localparam int FEAT_LEGACY_BIT = 1;
  localparam int FEAT_EXT_BIT = 2;
  localparam logic [2:0] FEAT_ALL = 3'h7;
  localparam logic [2:0] FEAT_RESET = 3'h1;
  // feature flag word layout
  localparam int FLAG_EXT_SAVE_BIT = 0;
  localparam int FLAG_OPT_SAVE_BIT = 1;
  // x87 status word fields
  localparam int STATUS_SUMMARY_BIT = 7;
  localparam int STATUS_TOP_LSB = 11;
  // reset values and tag encodings
  localparam logic [31:0] SIMD_CS_RESET = 32'h0000_1f80;
  localparam logic [15:0] FP_CONTROL_RESET = 16'h037f;
  localparam logic [15:0] FP_STATUS_RESET = 16'h0000;
  localparam logic [15:0] TAGS_ALL_EMPTY = 16'hffff;
  localparam logic [15:0] TAGS_ALL_VALID = 16'h0000;
  localparam logic [1:0] TAG_VALID = 2'h0;
  // execution request classes
  typedef enum logic [2:0] {
    OP_X87, OP_MEDIA64, OP_LEGACY_SIMD, OP_EXT_SIMD,
    OP_WAIT, OP_EXT_CTRL_WRITE, OP_EXT_CTRL_READ, OP_NONE
  } op_class_t;
  // fault codes
  typedef enum logic [2:0] {
    FAULT_NONE, FAULT_INVALID_OPCODE, FAULT_DEVICE_NOT_AVAILABLE,
    FAULT_GENERAL_PROTECTION, FAULT_SIMD_FP, FAULT_X87_PENDING
  } fault_t;
endpackage : simd_x87_pkg

// File: sim/simd_x87_state_enable_control_properties.sv
/*
  port-level assertions for the simd/x87 enable control block.
  assumes os and coproc control change only through the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module simd_x87_checker
  import simd_x87_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_class_i,
  input wire logic op_priv_i,
  input wire logic op_legacy_mode_i,
  input wire logic [3:0] op_reg_idx_i,
  input wire logic [63:0] op_ctrl_value_i,
  input wire logic simd_exc_i,
  input wire logic simd_exc_masked_i,
  input wire logic fault_o,
  input wire logic [2:0] fault_code_o
);
  logic [31:0] os_q;
  logic [3:0] cp_q;
  logic dna;
  logic ctl_ok;
  logic simd_ok;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // shadows, since the control words are not visible at the ports
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      os_q <= '0;
      cp_q <= '0;
    end else if (reg_we_i) begin
      if (reg_addr_i == IDX_OS_FEATURE_CTRL) os_q <= reg_wdata_i;
      if (reg_addr_i == IDX_COPROC_CTRL) cp_q <= reg_wdata_i[3:0];
    end
  end
  // gating terms in the order the block ranks its faults
  assign dna = !cp_q[2] && cp_q[1] && cp_q[3];
  assign ctl_ok = os_q[OS_EXT_SAVE_BIT] && op_priv_i;
  assign simd_ok = os_q[OS_LEGACY_SAVE_BIT] && !cp_q[2] && !dna
      && !(op_legacy_mode_i && op_reg_idx_i[3]);
  sequence s_ext_wr;
    op_valid_i && op_class_i == OP_EXT_CTRL_WRITE;
  endsequence
  sequence s_simd;
    op_valid_i && op_class_i == OP_LEGACY_SIMD && simd_ok && simd_exc_i;
  endsequence
  a_ext_wr_gate: assert property (s_ext_wr ##0 !os_q[OS_EXT_SAVE_BIT]
      |=> fault_o && fault_code_o == 3'h1)
    else $error("ext ctrl write not refused without os enable");
  a_ext_rd_gate: assert property (op_valid_i && op_class_i == OP_EXT_CTRL_READ
      && !os_q[OS_EXT_SAVE_BIT] |=> fault_o && fault_code_o == 3'h1)
    else $error("ext ctrl read not refused without os enable");
  a_ext_wr_priv: assert property (s_ext_wr ##0 os_q[OS_EXT_SAVE_BIT] && !op_priv_i
      |=> fault_o && fault_code_o == 3'h3)
    else $error("unprivileged ext ctrl write not refused");
  a_ext_x87_bit: assert property (s_ext_wr ##0 ctl_ok && !op_ctrl_value_i[0]
      |=> fault_o && fault_code_o == 3'h3)
    else $error("write clearing x87 bit accepted");
  a_ext_no_legacy: assert property (s_ext_wr ##0 ctl_ok
      && op_ctrl_value_i[2:1] == 2'h2 |=> fault_o && fault_code_o == 3'h3)
    else $error("extended without legacy state accepted");
  a_legacy_gate: assert property (op_valid_i && op_class_i == OP_LEGACY_SIMD
      && (!os_q[OS_LEGACY_SAVE_BIT] || cp_q[2]) |=> fault_o && fault_code_o == 3'h1)
    else $error("legacy simd ran without save support");
  a_simd_route: assert property (s_simd ##0 !simd_exc_masked_i
      |=> fault_o && fault_code_o == ($past(os_q[OS_SIMD_EXC_BIT]) ? 3'h4 : 3'h1))
    else $error("unmasked simd exception misrouted");
  a_masked_quiet: assert property (s_simd ##0 simd_exc_masked_i |=> !fault_o)
    else $error("masked simd exception faulted");
  a_dna_fault: assert property (op_valid_i && dna
      && (op_class_i == OP_X87 || op_class_i == OP_WAIT || op_class_i == OP_MEDIA64)
      |=> fault_o && fault_code_o == 3'h2)
    else $error("device not available fault missing");
endmodule : simd_x87_checker
bind simd_x87_state_enable_control simd_x87_checker u_chk (.*);
`default_nettype wire

// File: sim/simd_x87_state_enable_control_test.sv
/*
  self-checking bench for the simd/x87 enable control block.
  assumes the package register indices and a 40 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module simd_x87_state_enable_control_test;
  import simd_x87_pkg::*;
  logic ref_clk_i, resetn_i, reg_we_i, reg_re_i, op_valid_i, op_priv_i, op_legacy_mode_i;
  logic op_write_i, op_empty_tags_i, op_vec_wide_i, op_noncontrol_i, op_has_mem_i;
  logic simd_exc_i, simd_exc_masked_i, fault_o;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [2:0] op_class_i, fault_code_o;
  logic [3:0] op_reg_idx_i;
  logic [15:0] op_opcode_i;
  logic [63:0] op_ctrl_value_i, op_media_data_i, op_ip_i, op_dp_i, ext_ctrl_rdata_o;
  logic [63:0] media_rdata_o, last_ip_o, last_dp_o;
  logic [79:0] op_fp_data_i;
  logic [255:0] op_vec_data_i, vec_rdata_o;
  int mismatches, checked, cycles;
  simd_x87_state_enable_control DUT (.*);
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // runaway guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask : wr
  // read data stand from the cycle after the strobe until the next read
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), {32'h0, reg_rdata_o}, {32'h0, e});
  endtask : rc
  // ef is {fault, code}, judged in the single cycle fault_o stands
  task automatic op(input logic [2:0] c, input logic [3:0] idx, input logic [3:0] ef);
    @(posedge ref_clk_i);
    op_valid_i <= 1'b1;
    op_class_i <= c;
    op_reg_idx_i <= idx;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b0;
    #1 chk("fault", {60'h0, fault_o, fault_code_o}, {60'h0, ef});
  endtask : op
  task automatic t_reset();
    rc(IDX_SIMD_CONTROL_STATUS, 32'h0000_1f80);
    rc(IDX_FP_CONTROL_WORD, 32'h0000_037f);
    rc(IDX_FP_TAG_WORD, 32'h0000_ffff);
    rc(IDX_SUPPORTED_FEATURES, 32'h0000_0007);
    rc(IDX_FEATURE_FLAGS, 32'h0000_0003);
    rc(8'h3f, 32'h0);
    wr(IDX_FP_TAG_WORD, 32'h0);
    rc(IDX_FP_TAG_WORD, 32'h0000_ffff);
    wr(IDX_ENABLED_FEATURES, 32'h7);
    rc(IDX_ENABLED_FEATURES, 32'h1);
    wr(IDX_SIMD_CONTROL_STATUS, 32'h0000_ffc0);
    rc(IDX_SIMD_CONTROL_STATUS, 32'h0000_ffc0);
  endtask : t_reset
  task automatic t_ext_ctrl();
    op_priv_i <= 1'b1;
    op_ctrl_value_i <= 64'h7;
    op(OP_EXT_CTRL_WRITE, 4'h0, 4'h9);
    op(OP_EXT_CTRL_READ, 4'h0, 4'h9);
    wr(IDX_OS_FEATURE_CTRL, 32'h0004_0000);
    op_priv_i <= 1'b0;
    op(OP_EXT_CTRL_WRITE, 4'h0, 4'hb);
    op_priv_i <= 1'b1;
    op_ctrl_value_i <= 64'h6;
    op(OP_EXT_CTRL_WRITE, 4'h0, 4'hb);
    op_ctrl_value_i <= 64'h5;
    op(OP_EXT_CTRL_WRITE, 4'h0, 4'hb);
    rc(IDX_ENABLED_FEATURES, 32'h1);
    op_ctrl_value_i <= 64'h3;
    op(OP_EXT_CTRL_WRITE, 4'h0, 4'h0);
    rc(IDX_ENABLED_FEATURES, 32'h3);
    op_ctrl_value_i <= 64'h7;
    op(OP_EXT_CTRL_WRITE, 4'h0, 4'h0);
    rc(IDX_SAVE_AREA_SIZE, 32'd832);
    op(OP_EXT_CTRL_READ, 4'h0, 4'h0);
    chk("ext read", ext_ctrl_rdata_o, 64'h7);
  endtask : t_ext_ctrl
  task automatic t_simd();
    op(OP_LEGACY_SIMD, 4'h0, 4'h9);
    wr(IDX_OS_FEATURE_CTRL, 32'h0004_0200);
    simd_exc_i <= 1'b1;
    op(OP_LEGACY_SIMD, 4'h0, 4'h9);
    wr(IDX_OS_FEATURE_CTRL, 32'h0004_0600);
    op(OP_LEGACY_SIMD, 4'h0, 4'hc);
    simd_exc_masked_i <= 1'b1;
    op(OP_LEGACY_SIMD, 4'h0, 4'h0);
    simd_exc_i <= 1'b0;
    op_legacy_mode_i <= 1'b1;
    op(OP_LEGACY_SIMD, 4'h8, 4'h9);
    op(OP_LEGACY_SIMD, 4'h7, 4'h0);
    op_legacy_mode_i <= 1'b0;
    op_write_i <= 1'b1;
    op_vec_wide_i <= 1'b1;
    op_vec_data_i <= {64'h5a5a_0f0f_c3c3_9696, 192'h1};
    op(OP_EXT_SIMD, 4'hf, 4'h0);
    op_write_i <= 1'b0;
    op(OP_EXT_SIMD, 4'hf, 4'h0);
    chk("vec top", vec_rdata_o[255:192], 64'h5a5a_0f0f_c3c3_9696);
  endtask : t_simd
  task automatic t_dna();
    wr(IDX_COPROC_CTRL, 32'ha);
    op(OP_X87, 4'h0, 4'ha);
    op(OP_WAIT, 4'h0, 4'ha);
    op(OP_MEDIA64, 4'h0, 4'ha);
    wr(IDX_COPROC_CTRL, 32'he);
    op(OP_X87, 4'h0, 4'h0);
    op(OP_LEGACY_SIMD, 4'h0, 4'h9);
    wr(IDX_COPROC_CTRL, 32'h0);
  endtask : t_dna
  task automatic t_x87();
    op_write_i <= 1'b1;
    op_noncontrol_i <= 1'b1;
    op_has_mem_i <= 1'b1;
    op_fp_data_i <= 80'h1234_89ab_cdef_0123_4567;
    op_opcode_i <= 16'hd9f8;
    op_ip_i <= 64'h1000;
    op_dp_i <= 64'h2000;
    op(OP_X87, 4'h3, 4'h0);
    rc(IDX_LAST_FP_OPCODE, 32'h0000_01f8);
    chk("last ip", last_ip_o, 64'h1000);
    chk("last dp", last_dp_o, 64'h2000);
    op_media_data_i <= 64'hfeed_beef_0bad_f00d;
    op(OP_MEDIA64, 4'h5, 4'h0);
    wr(IDX_FP_REG_SELECT, 32'h5);
    rc(IDX_FP_REG_LO, 32'h0bad_f00d);
    rc(IDX_FP_REG_HI, 32'h0000_ffff);
    op_write_i <= 1'b0;
    // top at 7 and one flag set: media op clears top, leaves the flag
    wr(IDX_FP_STATUS_WORD, 32'h3801);
    op(OP_MEDIA64, 4'h3, 4'h0);
    chk("media", media_rdata_o, 64'h89ab_cdef_0123_4567);
    rc(IDX_FP_TAG_WORD, 32'h0);
    rc(IDX_FP_STATUS_WORD, 32'h0001);
    op_empty_tags_i <= 1'b1;
    op(OP_MEDIA64, 4'h3, 4'h0);
    rc(IDX_FP_TAG_WORD, 32'h0000_ffff);
    wr(IDX_FP_STATUS_WORD, 32'h80);
    op(OP_MEDIA64, 4'h3, 4'hd);
  endtask : t_x87
  initial begin
    {resetn_i, reg_we_i, reg_re_i, op_valid_i, op_priv_i, op_legacy_mode_i} = '0;
    {op_write_i, op_empty_tags_i, op_vec_wide_i, op_noncontrol_i, op_has_mem_i} = '0;
    {simd_exc_i, simd_exc_masked_i, reg_addr_i, reg_wdata_i, op_class_i} = '0;
    {op_reg_idx_i, op_opcode_i, op_ctrl_value_i, op_media_data_i} = '0;
    {op_ip_i, op_dp_i, op_fp_data_i, op_vec_data_i} = '0;
    {mismatches, checked, cycles} = '0;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_ext_ctrl();
    t_simd();
    t_dna();
    t_x87();
    close_out();
  end
endmodule : simd_x87_state_enable_control_test
`default_nettype wire
